// >>> core/ert_pkg.sv
// Purpose: Shared constants and types for the external request translator
// Assumes: Register offsets are byte addresses on a 32-bit classic Wishbone
// Notes:   Command codes are internal encodings, not bus pin values
package ert_pkg;

   // Address space
   localparam int PA_W          = 44;
   localparam int IO_BIT        = 43;
   localparam int BLK_LSB       = 6;
   localparam int SHORT_PA_MSB  = 27;

   // Queues
   localparam int CMD_W         = 5;
   localparam int ENT_W         = CMD_W + PA_W;
   localparam int Q_DEPTH       = 8;
   localparam logic [3:0] Q_FULL = 4'h8;

   // System address bus framing
   localparam int BEAT_W        = 15;
   localparam int FRAME_W       = 60;
   localparam logic [1:0] BEATS_LONG  = 2'h3;
   localparam logic [1:0] BEATS_SHORT = 2'h1;

   // Second-level cache port
   localparam int L2A_W         = 20;
   localparam int L2_IDX_LSB    = 4;
   localparam logic [2:0] L2_SIZE_MAX = 3'h4;
   localparam logic [19:0] L2_MASK_ALL = 20'hfffff;
   localparam logic [5:0] HALF_STEP = 6'h02;

   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CLK  = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;

   // Control register fields
   localparam int CTRL_SD_LSB    = 0;
   localparam int CTRL_ITD_LSB   = 3;
   localparam int CTRL_EVICT_BIT = 5;
   localparam int CTRL_CV_BIT    = 6;
   localparam int CTRL_STC_BIT   = 7;
   localparam int CTRL_MB_BIT    = 8;
   localparam int CTRL_BEAT4_BIT = 9;

   // Clock register fields
   localparam int CLK_DIV_LSB    = 0;
   localparam int CLK_RATIO_LSB  = 4;
   localparam int CLK_DUAL_BIT   = 9;
   localparam int CLK_SIZE_LSB   = 12;

   // Status register fields
   localparam int STAT_MAF_LSB   = 0;
   localparam int STAT_VAF_LSB   = 4;
   localparam int STAT_NXM_BIT   = 8;
   localparam int STAT_RCLK_BIT  = 9;

   // Reset values
   localparam logic       BEAT4_RST    = 1'b1;
   localparam logic [4:0] L2_RATIO_RST = 5'h08;
   localparam logic [2:0] L2_SIZE_RST  = 3'h4;

   typedef enum logic [CMD_W-1:0] {
      CMD_NONE, CMD_READ_BLOCK, CMD_INSTR_READ_BLOCK, CMD_READ_BLOCK_MODIFY,
      CMD_IO_BYTE_READ, CMD_IO_LONGWORD_READ, CMD_IO_QUADWORD_READ,
      CMD_IO_BYTE_WRITE, CMD_IO_LONGWORD_WRITE, CMD_IO_QUADWORD_WRITE,
      CMD_INVALID_TO_DIRTY, CMD_SHARED_TO_DIRTY, CMD_CLEAN_TO_DIRTY,
      CMD_STCOND_CHANGE_TO_DIRTY, CMD_EVICT, CMD_CLEAN_VICTIM,
      CMD_VICTIM_WRITE, CMD_BARRIER
   } ert_cmd_t;

   typedef enum logic [3:0] {
      OP_LOAD, OP_PREFETCH, OP_PREFETCH_MODIFY, OP_IFETCH, OP_STORE,
      OP_STCOND, OP_WRITE_HINT, OP_EVICT_BLOCK, OP_BARRIER
   } ert_op_t;

   typedef enum logic [2:0] {
      RSP_DONE, RSP_FAIL, RSP_SENT, RSP_NOP, RSP_SET_MODIFY
   } ert_rsp_t;

endpackage

// >>> core/ert_translator.sv
// Purpose: Turns core cache requests into system bus commands
// Assumes: Requests come from logic on clk_i; nxm and return clock are pins
// Notes:   One request per cycle while ready; result one cycle later
// Operation
// - 44-bit address, top bit selects I/O
// - Memory references always a 64-byte block
// - Eight-entry miss queue and victim queue
// - 15-bit address bus, two or four beats
// - Free-running forwarded clocks, programmable period
// - Cache ratio 1.5-4.0 halves, 5-8; 1.5 dual only; a 1.5 ratio already set stays set when dual is later cleared
// - Cache 1MB-16MB, 128-bit data, 20-bit address
// - Prefetches follow load/store flow, I/O cleared
// - Load hits done, double miss reads block
// - I/O load reads byte, longword or quadword
// - Fetch hits served, double miss reads instruction block
// - Store writable hit done, else set-dirty or modify
// - I/O store writes byte, longword or quadword
// - Store-conditional misses fail, unwritable hit set-dirty
// - I/O store-conditional succeeds, longword or quadword write
// - Write hint hit/set-dirty/invalid-to-dirty, I/O no-op
// - Evict I/O no-op, notify only if enabled+match
// - Evicted victim: clean-victim if enabled, dirty writes
// - Set-dirty config: internal ack or shared/clean commands
// - Invalid-to-dirty config: ack, send, or read-modify
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module ert_translator
   import ert_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Core request
   input  wire logic              req_valid_i,
   input  wire ert_op_t           req_op_i,
   input  wire logic [PA_W-1:0]   req_addr_i,
   input  wire logic [1:0]        req_size_i,
   input  wire logic              dc_hit_i,
   input  wire logic              dc_w_i,
   input  wire logic              bc_hit_i,
   input  wire logic              bc_w_i,
   input  wire logic              blk_shared_i,
   input  wire logic              idx_match_i,
   input  wire logic              idx_dirty_i,
   output logic                   req_ready_o,
   output logic                   resp_valid_o,
   output ert_rsp_t               resp_code_o,
   // System port
   output logic      [BEAT_W-1:0] sys_addr_o,
   output logic                   sys_addr_valid_o,
   output logic                   sys_addr_out_clock_o,
   input  wire logic              sys_addr_return_clock_i,
   input  wire logic              nxm_i,
   // Second-level cache port
   output logic      [L2A_W-1:0]  l2_addr_o,
   output logic      [3:0]        l2_data_out_clocks_o,
   output logic                   l2_tag_out_clock_o
);

   typedef struct packed {
      logic                       ack;
      logic [31:0]                dat;
      logic [2:0]                 sd_cfg;
      logic [1:0]                 itd_cfg;
      logic                       evict_en, cv_en, stc_en, mb_en, beat4;
      logic [2:0]                 sys_div;
      logic [4:0]                 l2_ratio;
      logic                       dual;
      logic [2:0]                 l2_size;
      logic                       nxm_s1, nxm_s2, nxm, rck_s1, rck_s2, rck_s3, rck_seen;
      logic [Q_DEPTH-1:0][ENT_W-1:0] miss_request_queue;
      logic [2:0]                 maf_wp, maf_rp;
      logic [3:0]                 maf_cnt;
      logic [Q_DEPTH-1:0][ENT_W-1:0] victim_address_queue;
      logic [2:0]                 vaf_wp, vaf_rp;
      logic [3:0]                 vaf_cnt;
      logic [FRAME_W-1:0]         shift;
      logic [1:0]                 beats_left;
      logic                       sys_v;
      logic [BEAT_W-1:0]          sys_addr;
      logic [2:0]                 div_cnt;
      logic                       sys_clk;
      logic [5:0]                 l2_acc;
      logic                       l2_clk;
      logic [PA_W-1:0]            l2_pa;
      logic [L2A_W-1:0]           l2_addr;
      logic                       ready, resp_v;
      ert_rsp_t                   resp;
   } ert_state_t;

   ert_state_t r;
   ert_state_t n;

   function automatic ert_cmd_t io_cmd(input logic [1:0] size, input logic wr);
      ert_cmd_t c;
      unique case (size)
         2'h0, 2'h1: c = wr ? CMD_IO_BYTE_WRITE : CMD_IO_BYTE_READ;
         2'h2:       c = wr ? CMD_IO_LONGWORD_WRITE : CMD_IO_LONGWORD_READ;
         2'h3:       c = wr ? CMD_IO_QUADWORD_WRITE : CMD_IO_QUADWORD_READ;
      endcase
      return c;
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction

   // Half-cycle ratio codes the cache port accepts
   function automatic logic ratio_ok(input logic [4:0] h, input logic dual);
      logic ok;
      unique case (h)
         5'h03:                             ok = dual;
         5'h04, 5'h05, 5'h06, 5'h07, 5'h08: ok = 1'b1;
         5'h0a, 5'h0c, 5'h0e, 5'h10:        ok = 1'b1;
         default:                           ok = 1'b0;
      endcase
      return ok;
   endfunction

   always_comb begin
      logic [PA_W-1:0]    pa, pa_out;
      logic               io, push_m, push_v, pop_m, pop_v, sd_req, sd_ext, hit_w, hit_nw;
      ert_cmd_t           m_cmd, v_cmd, t_cmd;
      ert_op_t            flow;
      ert_rsp_t           rsp;
      logic [ENT_W-1:0]   ent;
      logic [2:0]         tid;
      logic [FRAME_W-1:0] fr;
      logic [31:0]        rv, wv, msk;
      logic [5:0]         acc2;
      n        = r;
      pa       = req_addr_i;
      {pa_out, io, push_m, push_v, pop_m, pop_v, sd_req, sd_ext, hit_w, hit_nw} = '0;
      m_cmd    = CMD_NONE;
      v_cmd    = CMD_NONE;
      t_cmd    = CMD_NONE;
      flow     = req_op_i;
      rsp      = RSP_DONE;
      {ent, tid, fr, rv, wv, acc2} = '0;
      msk      = lane_mask(wb_sel_i);
      n.ack    = 1'b0;
      n.resp_v = 1'b0;
      // Pin synchronisers
      n.nxm_s1 = nxm_i;
      n.nxm_s2 = r.nxm_s1;
      n.rck_s1 = sys_addr_return_clock_i;
      n.rck_s2 = r.rck_s1;
      n.rck_s3 = r.rck_s2;
      // Register read image
      unique case (wb_adr_i)
         REG_CTRL: begin
            rv[CTRL_SD_LSB +: 3]  = r.sd_cfg;
            rv[CTRL_ITD_LSB +: 2] = r.itd_cfg;
            rv[CTRL_EVICT_BIT]    = r.evict_en;
            rv[CTRL_CV_BIT]       = r.cv_en;
            rv[CTRL_STC_BIT]      = r.stc_en;
            rv[CTRL_MB_BIT]       = r.mb_en;
            rv[CTRL_BEAT4_BIT]    = r.beat4;
         end
         REG_CLK: begin
            rv[CLK_DIV_LSB +: 3]   = r.sys_div;
            rv[CLK_RATIO_LSB +: 5] = r.l2_ratio;
            rv[CLK_DUAL_BIT]       = r.dual;
            rv[CLK_SIZE_LSB +: 3]  = r.l2_size;
         end
         REG_STAT: begin
            rv[STAT_MAF_LSB +: 4] = r.maf_cnt;
            rv[STAT_VAF_LSB +: 4] = r.vaf_cnt;
            rv[STAT_NXM_BIT]      = r.nxm;
            rv[STAT_RCLK_BIT]     = r.rck_seen;
         end
         default: rv = '0;
      endcase
      wv = (rv & ~msk) | (wb_dat_i & msk);
      // Sticky flags; a new event beats a clear in the same cycle
      n.nxm      = r.nxm | r.nxm_s2;
      n.rck_seen = r.rck_seen | (r.rck_s2 ^ r.rck_s3);
      // Wishbone slave, one wait state; unmapped reads zero
      if (wb_cyc_i && wb_stb_i && !r.ack) begin
         n.ack = 1'b1;
         n.dat = wb_we_i ? '0 : rv;
         if (wb_we_i) begin
            unique case (wb_adr_i)
               REG_CTRL: begin
                  n.sd_cfg   = wv[CTRL_SD_LSB +: 3];
                  n.itd_cfg  = wv[CTRL_ITD_LSB +: 2];
                  n.evict_en = wv[CTRL_EVICT_BIT];
                  n.cv_en    = wv[CTRL_CV_BIT];
                  n.stc_en   = wv[CTRL_STC_BIT];
                  n.mb_en    = wv[CTRL_MB_BIT];
                  n.beat4    = wv[CTRL_BEAT4_BIT];
               end
               REG_CLK: begin
                  n.sys_div = wv[CLK_DIV_LSB +: 3];
                  n.dual    = wv[CLK_DUAL_BIT];
                  // Illegal ratio keeps the old one
                  if (ratio_ok(wv[CLK_RATIO_LSB +: 5], wv[CLK_DUAL_BIT])) begin
                     n.l2_ratio = wv[CLK_RATIO_LSB +: 5];
                  end
                  if (wv[CLK_SIZE_LSB +: 3] <= L2_SIZE_MAX) begin
                     n.l2_size = wv[CLK_SIZE_LSB +: 3];
                  end
               end
               REG_STAT: begin
                  n.nxm      = r.nxm_s2 | (r.nxm & ~wv[STAT_NXM_BIT]);
                  n.rck_seen = (r.rck_s2 ^ r.rck_s3) | (r.rck_seen & ~wv[STAT_RCLK_BIT]);
               end
               default: n.dat = '0;
            endcase
         end
      end
      // Request translation
      if (req_valid_i && r.ready) begin
         if (req_op_i == OP_PREFETCH || req_op_i == OP_PREFETCH_MODIFY) begin
            pa[IO_BIT] = 1'b0;
            flow = (req_op_i == OP_PREFETCH) ? OP_LOAD : OP_STORE;
         end
         io     = pa[IO_BIT];
         hit_w  = dc_hit_i ? dc_w_i : (bc_hit_i && bc_w_i);
         hit_nw = (dc_hit_i || bc_hit_i) && !hit_w;
         unique case (flow)
            OP_LOAD, OP_PREFETCH: begin
               if (io) begin
                  m_cmd = io_cmd(req_size_i, 1'b0);
               end else if (!dc_hit_i && !bc_hit_i) begin
                  m_cmd = CMD_READ_BLOCK;
               end
            end
            OP_IFETCH: begin
               if (!dc_hit_i && !bc_hit_i) begin
                  m_cmd = CMD_INSTR_READ_BLOCK;
               end
            end
            OP_STORE, OP_PREFETCH_MODIFY: begin
               if (io) begin
                  m_cmd = io_cmd(req_size_i, 1'b1);
               end else if (hit_nw) begin
                  sd_req = 1'b1;
               end else if (!hit_w) begin
                  m_cmd = CMD_READ_BLOCK_MODIFY;
               end
            end
            OP_STCOND: begin
               if (io) begin
                  m_cmd = (req_size_i == 2'h3) ? CMD_IO_QUADWORD_WRITE : CMD_IO_LONGWORD_WRITE;
               end else if (!dc_hit_i) begin
                  rsp = RSP_FAIL;
               end else if (!dc_w_i) begin
                  if (r.stc_en) begin
                     m_cmd = CMD_STCOND_CHANGE_TO_DIRTY;
                  end else begin
                     sd_req = 1'b1;
                  end
               end
            end
            OP_WRITE_HINT: begin
               if (io) begin
                  rsp = RSP_NOP;
               end else if (hit_nw) begin
                  sd_req = 1'b1;
               end else if (!hit_w) begin
                  unique case (r.itd_cfg)
                     2'h0:       rsp = RSP_SET_MODIFY;
                     2'h1:       m_cmd = CMD_INVALID_TO_DIRTY;
                     2'h2, 2'h3: m_cmd = CMD_READ_BLOCK_MODIFY;
                  endcase
               end
            end
            OP_EVICT_BLOCK: begin
               if (io) begin
                  rsp = RSP_NOP;
               end else begin
                  if (r.evict_en && idx_match_i) begin
                     m_cmd = CMD_EVICT;
                  end
                  if (idx_match_i && idx_dirty_i) begin
                     v_cmd = CMD_VICTIM_WRITE;
                  end else if (idx_match_i && r.cv_en) begin
                     v_cmd = CMD_CLEAN_VICTIM;
                  end
               end
            end
            OP_BARRIER: m_cmd = r.mb_en ? CMD_BARRIER : CMD_NONE;
            default: rsp = RSP_NOP;
         endcase
         // Set-dirty flow: bit 0 clean, bit 1 shared goes external
         if (sd_req) begin
            sd_ext = blk_shared_i ? r.sd_cfg[1] : r.sd_cfg[0];
            if (sd_ext) begin
               m_cmd = blk_shared_i ? CMD_SHARED_TO_DIRTY : CMD_CLEAN_TO_DIRTY;
            end else begin
               rsp = RSP_SET_MODIFY;
            end
         end
         // Memory commands name the whole block
         pa_out = io ? pa : {pa[PA_W-1:BLK_LSB], {BLK_LSB{1'b0}}};
         push_m = (m_cmd != CMD_NONE);
         push_v = (v_cmd != CMD_NONE);
         rsp      = (push_m || push_v) ? RSP_SENT : rsp;
         n.resp_v = 1'b1;
         n.resp   = rsp;
         n.l2_pa  = pa;
      end
      // Queue writes; ready guarantees a free slot in each
      if (push_m) begin
         n.miss_request_queue[r.maf_wp] = {m_cmd, pa_out};
         n.maf_wp = r.maf_wp + 3'h1;
      end
      if (push_v) begin
         n.victim_address_queue[r.vaf_wp] = {v_cmd, pa_out};
         n.vaf_wp = r.vaf_wp + 3'h1;
      end
      // Address bus sender; victims drain first so fills can land
      if (r.beats_left == 2'h0) begin
         pop_v = (r.vaf_cnt != 4'h0);
         pop_m = !pop_v && (r.maf_cnt != 4'h0);
         if (pop_v) begin
            ent = r.victim_address_queue[r.vaf_rp];
            tid = r.vaf_rp;
            n.vaf_rp = r.vaf_rp + 3'h1;
         end else if (pop_m) begin
            ent = r.miss_request_queue[r.maf_rp];
            tid = r.maf_rp;
            n.maf_rp = r.maf_rp + 3'h1;
         end
         t_cmd = ert_cmd_t'(ent[ENT_W-1 -: CMD_W]);
         // Short frames carry only the low block address
         fr = r.beat4 ? {t_cmd, tid, ent[PA_W-1:0], 8'h00} : {t_cmd, tid, ent[SHORT_PA_MSB:BLK_LSB], 30'h0};
         n.sys_v      = pop_v || pop_m;
         n.sys_addr   = n.sys_v ? fr[FRAME_W-1 -: BEAT_W] : '0;
         n.shift      = fr << BEAT_W;
         n.beats_left = !n.sys_v ? 2'h0 : (r.beat4 ? BEATS_LONG : BEATS_SHORT);
      end else begin
         n.sys_v      = 1'b1;
         n.sys_addr   = r.shift[FRAME_W-1 -: BEAT_W];
         n.shift      = r.shift << BEAT_W;
         n.beats_left = r.beats_left - 2'h1;
      end
      n.maf_cnt = r.maf_cnt + {3'h0, push_m} - {3'h0, pop_m};
      n.vaf_cnt = r.vaf_cnt + {3'h0, push_v} - {3'h0, pop_v};
      n.ready   = (n.maf_cnt < Q_FULL) && (n.vaf_cnt < Q_FULL);
      // Forwarded system clock, half period of sys_div+1 cycles
      if (r.div_cnt >= r.sys_div) begin
         n.div_cnt = '0;
         n.sys_clk = !r.sys_clk;
      end else begin
         n.div_cnt = r.div_cnt + 3'h1;
      end
      // Cache cycle boundaries from a half-cycle accumulator
      acc2 = r.l2_acc + HALF_STEP;
      if (acc2 >= {1'b0, r.l2_ratio}) begin
         n.l2_acc  = acc2 - {1'b0, r.l2_ratio};
         n.l2_clk  = !r.l2_clk;
         n.l2_addr = r.l2_pa[L2_IDX_LSB +: L2A_W] & (L2_MASK_ALL >> (L2_SIZE_MAX - r.l2_size));
      end else begin
         n.l2_acc = acc2;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r          <= '0;
         r.beat4    <= BEAT4_RST;
         r.l2_ratio <= L2_RATIO_RST;
         r.l2_size  <= L2_SIZE_RST;
         r.ready    <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign wb_dat_o             = r.dat;
   assign wb_ack_o             = r.ack;
   assign req_ready_o          = r.ready;
   assign resp_valid_o         = r.resp_v;
   assign resp_code_o          = r.resp;
   assign sys_addr_o           = r.sys_addr;
   assign sys_addr_valid_o     = r.sys_v;
   assign sys_addr_out_clock_o = r.sys_clk;
   assign l2_addr_o            = r.l2_addr;
   assign l2_data_out_clocks_o = {4{r.l2_clk}};
   assign l2_tag_out_clock_o   = r.l2_clk;

endmodule // ert_translator

// >>> tb/ert_checker_properties.sv
// Purpose: Port-level checks for the request translator
// Assumes: Bound to ert_translator, one clock domain
// Notes:   Codes checked only where the flows fix them
`timescale 1ns/1ps
module ert_checker
   import ert_pkg::*;
(
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              req_valid_i,
   input wire ert_op_t           req_op_i,
   input wire logic [PA_W-1:0]   req_addr_i,
   input wire logic              dc_hit_i,
   input wire logic              req_ready_o,
   input wire logic              resp_valid_o,
   input wire ert_rsp_t          resp_code_o,
   input wire logic [BEAT_W-1:0] sys_addr_o,
   input wire logic              sys_addr_valid_o,
   input wire logic              sys_addr_out_clock_o,
   input wire logic [3:0]        l2_data_out_clocks_o,
   input wire logic              l2_tag_out_clock_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic taken = req_valid_i && req_ready_o;
   wire logic io    = req_addr_i[IO_BIT];
   chk_resp_next: assert property (taken |=> resp_valid_o)
      else $error("no response after a taken request");
   chk_resp_cause: assert property (resp_valid_o |-> $past(taken))
      else $error("response without a request");
   chk_load_hit: assert property (taken && req_op_i == OP_LOAD && !io && dc_hit_i |=> resp_code_o == RSP_DONE)
      else $error("load hit not done locally");
   chk_io_load: assert property (taken && req_op_i == OP_LOAD && io |=> resp_code_o == RSP_SENT)
      else $error("io load not sent");
   chk_stc_miss: assert property (taken && req_op_i == OP_STCOND && !io && !dc_hit_i |=> resp_code_o == RSP_FAIL)
      else $error("store-conditional miss did not fail");
   chk_hint_io: assert property (taken && req_op_i == OP_WRITE_HINT && io |=> resp_code_o == RSP_NOP)
      else $error("io write hint not a no-op");
   chk_bus_idle: assert property (!sys_addr_valid_o |-> sys_addr_o == 15'h0)
      else $error("address bus not idle between frames");
   chk_frame_min: assert property ($rose(sys_addr_valid_o) |-> sys_addr_valid_o[*2])
      else $error("frame shorter than two beats");
   chk_l2_clocks: assert property (l2_data_out_clocks_o == {4{l2_tag_out_clock_o}})
      else $error("cache clocks out of step");
   chk_sys_clock: assert property (1'b1 |-> ##[1:9] $changed(sys_addr_out_clock_o))
      else $error("forwarded clock stopped");
   cover property (taken ##1 resp_code_o == RSP_FAIL);
   cover property ($rose(sys_addr_valid_o));
   cover property (req_valid_i && !req_ready_o);
endmodule // ert_checker

// >>> tb/ert_sys_partner.sv
// Purpose: System-side model facing the address bus
// Assumes: Four-beat frames for the range check
`timescale 1ns/1ps
module ert_sys_partner #(parameter int DLY = 3) (
   input  wire logic        clk_i,
   input  wire logic        fwd_clk_i,
   input  wire logic        beat_valid_i,
   input  wire logic [14:0] beat_i,
   output logic             ret_clk_o,
   output logic             nxm_o
);
   logic [7:0] dly_r = 8'h0;
   logic       prev_r = 1'b0;
   always_ff @(posedge clk_i) begin
      dly_r  <= {dly_r[6:0], fwd_clk_i};
      prev_r <= beat_valid_i;
      // Memory at address bit 37 and above is absent here
      nxm_o  <= beat_valid_i && !prev_r && beat_i[5:0] != 6'h0;
   end
   // Turned round, same rate, late
   assign ret_clk_o = dly_r[DLY];
endmodule // ert_sys_partner

// >>> tb/ert_translator_tb_top.sv
// Purpose: Self-checking bench for the request translator
// Assumes: Wishbone master and core driven on rising edges
// Notes:   Response codes come from a flow model in the bench
`timescale 1ns/1ps
module ert_translator_tb_top;
   import ert_pkg::*;
   logic        clk_i = 1'b0, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, req_valid_i, req_ready_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, l2_data_out_clocks_o;
   logic [31:0] wb_dat_i, wb_dat_o;
   ert_op_t     req_op_i;
   ert_rsp_t    resp_code_o;
   logic [43:0] req_addr_i;
   logic [1:0]  req_size_i;
   logic        dc_hit_i, dc_w_i, bc_hit_i, bc_w_i, blk_shared_i, idx_match_i, idx_dirty_i, resp_valid_o;
   logic [14:0] sys_addr_o;
   logic [19:0] l2_addr_o;
   logic        sys_addr_valid_o, sys_addr_out_clock_o, sys_addr_return_clock_i, nxm_i, l2_tag_out_clock_o;
   int          compares = 0, miscompares = 0, cyc = 0, ctl = 32'h200;
   ert_op_t     tops[9] = '{OP_LOAD, OP_IFETCH, OP_STORE, OP_PREFETCH, OP_LOAD, OP_LOAD, OP_STORE, OP_STCOND,
                            OP_STCOND};
   logic [2:0]  tio[9] = '{3'h3, 3'h3, 3'h3, 3'h7, 3'h4, 3'h6, 3'h7, 3'h6, 3'h7};
   ert_cmd_t    tcmd[9] = '{CMD_READ_BLOCK, CMD_INSTR_READ_BLOCK, CMD_READ_BLOCK_MODIFY, CMD_READ_BLOCK,
                            CMD_IO_BYTE_READ, CMD_IO_LONGWORD_READ, CMD_IO_QUADWORD_WRITE,
                            CMD_IO_LONGWORD_WRITE, CMD_IO_QUADWORD_WRITE};
   ert_translator dut (.*);
   ert_sys_partner #(.DLY(3)) sys (.clk_i(clk_i), .fwd_clk_i(sys_addr_out_clock_o), .beat_valid_i(sys_addr_valid_o),
      .beat_i(sys_addr_o), .ret_clk_o(sys_addr_return_clock_i), .nxm_o(nxm_i));
   always #25 clk_i = ~clk_i;
   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Hang guard well above the expected run length
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // Flag order: dirty, match, shared, bc_w, bc_hit, dc_w, dc_hit
   function automatic ert_rsp_t model(input ert_op_t op, input logic io, input logic [6:0] f);
      logic hit, hw;
      ert_rsp_t sd;
      hit = f[0] | f[2];
      hw  = f[0] ? f[1] : f[3];
      sd  = (f[4] ? ctl[1] : ctl[0]) ? RSP_SENT : RSP_SET_MODIFY;
      case (op)
         OP_LOAD, OP_IFETCH: return (io || !hit) ? RSP_SENT : RSP_DONE;
         OP_PREFETCH: return hit ? RSP_DONE : RSP_SENT;
         OP_STORE, OP_PREFETCH_MODIFY: return (io && op == OP_STORE) ? RSP_SENT : !hit ? RSP_SENT : hw ? RSP_DONE : sd;
         OP_STCOND: return io ? RSP_SENT : !f[0] ? RSP_FAIL : f[1] ? RSP_DONE : ctl[7] ? RSP_SENT : sd;
         OP_WRITE_HINT: return io ? RSP_NOP : hit ? (hw ? RSP_DONE : sd) : ctl[4:3] == 0 ? RSP_SET_MODIFY : RSP_SENT;
         OP_EVICT_BLOCK: return !io && f[5] && (ctl[5] || ctl[6] || f[6]) ? RSP_SENT : io ? RSP_NOP : RSP_DONE;
         OP_BARRIER: return ctl[8] ? RSP_SENT : RSP_DONE;
         default: return RSP_NOP;
      endcase
   endfunction
   task automatic req(input ert_op_t op, input logic [43:0] a, input logic [1:0] sz, input logic [6:0] f);
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_op_i    <= op;
      req_addr_i  <= a;
      req_size_i  <= sz;
      {idx_dirty_i, idx_match_i, blk_shared_i, bc_w_i, bc_hit_i, dc_w_i, dc_hit_i} <= f;
      do @(posedge clk_i); while (req_ready_o !== 1'b1);
      req_valid_i <= 1'b0;
      @(posedge clk_i);
      chk(resp_valid_o, 1'b1);
      chk(resp_code_o, model(op, a[43], f));
   endtask
   initial begin
      logic [31:0] q;
      logic [59:0] fr;
      logic [43:0] a;
      ert_op_t     op;
      void'($urandom(59911));
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 47'h0};
      {req_valid_i, req_op_i, req_addr_i, req_size_i} = 51'h0;
      {idx_dirty_i, idx_match_i, blk_shared_i, bc_w_i, bc_hit_i, dc_w_i, dc_hit_i} = 7'h0;
      repeat (16) @(posedge clk_i);
      rst_i    <= 1'b0;
      wb_sel_i <= 4'hf;
      wb(1'b0, REG_CTRL, 32'h0, q);
      chk(q, 32'h200);
      wb(1'b0, REG_CLK, 32'h0, q);
      chk(q, 32'h4080);
      wb(1'b0, 8'h0c, 32'h0, q);
      chk(q, 32'h0);
      for (int i = 0; i < 9; i++) begin
         a = {tio[i][2], 6'h0, 37'h01_2345_67ab};
         req(tops[i], a, tio[i][1:0], 7'h0);
         while (sys_addr_valid_o !== 1'b1) @(posedge clk_i);
         fr = 60'(sys_addr_o);
         repeat (3) @(posedge clk_i) fr = {fr[44:0], sys_addr_o};
         chk(fr[59:55], tcmd[i]);
         chk(fr[51:14], {a[43] && tops[i] != OP_PREFETCH, a[42:6]});
         if (!a[43] || tops[i] == OP_PREFETCH) chk(fr[13:8], 6'h0);
      end
      for (int i = 0; i < 200; i++) begin
         if (i % 25 == 0) begin
            ctl = ($urandom & 32'h1ff) | 32'h200;
            wb(1'b1, REG_CTRL, ctl, q);
            wb(1'b0, REG_CTRL, 32'h0, q);
            chk(q, ctl);
         end
         op = ert_op_t'($urandom % 9);
         a = 44'({$urandom, $urandom});
         a[42:37] = 6'h0;
         if (op == OP_IFETCH) a[43] = 1'b0;
         req(op, a, 2'($urandom), 7'($urandom));
      end
      req(OP_LOAD, {1'b0, 6'h1, 37'h0_00ab_cdc0}, 2'h3, 7'h0);
      repeat (100) @(posedge clk_i);
      chk(l2_addr_o, 20'habcdc);
      wb(1'b0, REG_STAT, 32'h0, q);
      chk(q[9:0], 10'h300);
      wb(1'b1, REG_STAT, 32'h100, q);
      wb(1'b0, REG_STAT, 32'h0, q);
      chk(q[8], 1'b0);
      close_out();
   end
endmodule // ert_translator_tb_top
bind ert_translator ert_checker chk (.*);
